// file: rtl/icd_pkg.sv
// Constants and types for the index compare / decimal adjust execution unit
package icd_pkg;
   // ------------------------------------------------------------
   // Opcodes
   // ------------------------------------------------------------
   localparam logic [7:0] OP_PFX_Y = 8'h18;
   localparam logic [7:0] OP_PFX_1A = 8'h1A;
   localparam logic [7:0] OP_PFX_CD = 8'hCD;
   localparam logic [7:0] OP_CMP_IMM = 8'h8C;
   localparam logic [7:0] OP_CMP_DIR = 8'h9C;
   localparam logic [7:0] OP_CMP_EXT = 8'hBC;
   localparam logic [7:0] OP_CMP_IND = 8'hAC;
   localparam logic [7:0] OP_DEC_ADJ = 8'h19;
   // ------------------------------------------------------------
   // Bus and arithmetic constants
   // ------------------------------------------------------------
   localparam logic [15:0] IDLE_ADDR = 16'hFFFF;
   localparam logic [7:0] ZERO_PAGE = 8'h00;
   localparam logic [3:0] NIB_NINE = 4'h9;
   localparam logic [3:0] NIB_LOW_CORR = 4'h6;
   localparam logic [3:0] NIB_HIGH_CORR = 4'h6;
   // ------------------------------------------------------------
   // Condition flag bit positions and reset values
   // ------------------------------------------------------------
   localparam int FLG_C = 0;
   localparam int FLG_V = 1;
   localparam int FLG_Z = 2;
   localparam int FLG_N = 3;
   localparam int FLG_H = 5;
   localparam logic [7:0] FLAGS_RST = 8'hD0;
   localparam logic [15:0] REG16_RST = 16'h0000;
   localparam logic [7:0] REG8_RST = 8'h00;
   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_FETCH = 4'b0000,
      ST_OPC2 = 4'b0001,
      ST_ARG1 = 4'b0010,
      ST_ARG2 = 4'b0011,
      ST_IDLE_IDX = 4'b0100,
      ST_OPND_HI = 4'b0101,
      ST_OPND_LO = 4'b0110,
      ST_IDLE_END = 4'b0111,
      ST_DAA_2 = 4'b1000
   } icd_state_t;
   typedef enum logic [1:0] {
      MD_IMM = 2'b00,
      MD_DIR = 2'b01,
      MD_EXT = 2'b10,
      MD_IND = 2'b11
   } icd_mode_t;
endpackage : icd_pkg

// file: rtl/icd_cmp_if.sv
// Carrier between the sequencer and the compare flag unit
`timescale 1ns/1ps
`default_nettype none
interface icd_cmp_if;
   logic [15:0] idx;
   logic [15:0] opnd;
   logic n;
   logic z;
   logic v;
   logic c;
   modport src (output idx, output opnd, input n, input z, input v, input c);
   modport alu (input idx, input opnd, output n, output z, output v, output c);
endinterface : icd_cmp_if
`default_nettype wire

// file: rtl/icd_cmp_flags.sv
// 16-bit compare flag unit
`timescale 1ns/1ps
`default_nettype none
module icd_cmp_flags (
   icd_cmp_if.alu cmp
);
   logic [15:0] diff;
   logic ix15;
   logic m15;
   logic r15;
   always_comb begin
      diff = cmp.idx - cmp.opnd;
      ix15 = cmp.idx[15];
      m15 = cmp.opnd[15];
      r15 = diff[15];
      cmp.n = r15;
      cmp.z = (diff == 16'h0000);
      cmp.v = (ix15 & ~m15 & ~r15) | (~ix15 & m15 & r15);
      cmp.c = (~ix15 & m15) | (m15 & r15) | (r15 & ~ix15);
   end
endmodule // icd_cmp_flags
`default_nettype wire

// file: rtl/icd_exec.sv
// Execution sequencer for index compares and decimal adjust
`timescale 1ns/1ps
`default_nettype none
module icd_exec
   import icd_pkg::*;
(
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   // Memory bus
   output logic [15:0] o_addr,
   output logic o_rd_wr,
   input wire logic [7:0] i_rdata,
   // Architectural state load and observation
   input wire logic i_load,
   input wire logic [15:0] i_pc,
   input wire logic [15:0] i_first_index_register,
   input wire logic [15:0] i_second_index_register,
   input wire logic [7:0] i_primary_accumulator,
   input wire logic [7:0] i_condition_flags,
   output logic [15:0] o_pc,
   output logic [15:0] o_first_index_register,
   output logic [15:0] o_second_index_register,
   output logic [7:0] o_primary_accumulator,
   output logic [7:0] o_condition_flags,
   output logic o_instr_done,
   output logic o_illegal
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   icd_state_t state_q;
   icd_state_t state_d;
   icd_mode_t mode_q;
   logic use_y_q;
   logic idx_y_q;
   logic [1:0] pfx_q;
   logic [15:0] pc_q;
   logic [15:0] ix_q;
   logic [15:0] iy_q;
   logic [7:0] acc_q;
   logic [7:0] flags_q;
   logic [15:0] ea_q;
   logic [15:0] opnd_q;
   logic [7:0] arg_q;
   logic done_q;
   logic illegal_q;
   logic [15:0] addr_d;
   icd_cmp_if cmp_bus ();
   icd_cmp_flags u_cmp (
      .cmp(cmp_bus)
   );
   assign cmp_bus.idx = use_y_q ? iy_q : ix_q;
   assign cmp_bus.opnd = opnd_q;
   // ------------------------------------------------------------
   // Decimal adjust correction
   // ------------------------------------------------------------
   logic [3:0] hi_nib;
   logic [3:0] lo_nib;
   logic lo_af;
   logic corr_lo;
   logic corr_hi;
   logic [7:0] corr_byte;
   logic [7:0] daa_res;
   always_comb begin
      hi_nib = acc_q[7:4];
      lo_nib = acc_q[3:0];
      lo_af = (lo_nib > NIB_NINE);
      corr_lo = flags_q[FLG_H] | lo_af;
      corr_hi = flags_q[FLG_C] | (hi_nib > NIB_NINE) | ((hi_nib == NIB_NINE) & lo_af);
      corr_byte = {(corr_hi ? NIB_HIGH_CORR : 4'h0), (corr_lo ? NIB_LOW_CORR : 4'h0)};
      daa_res = acc_q + corr_byte;
   end
   // ------------------------------------------------------------
   // Next state and bus address
   // ------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      addr_d = IDLE_ADDR;
      case (state_q)
         ST_FETCH: begin
            addr_d = pc_q;
            if (i_rdata == OP_PFX_Y || i_rdata == OP_PFX_1A || i_rdata == OP_PFX_CD) begin
               state_d = ST_OPC2;
            end else if (i_rdata == OP_DEC_ADJ) begin
               state_d = ST_DAA_2;
            end else if (i_rdata == OP_CMP_IMM || i_rdata == OP_CMP_DIR ||
                         i_rdata == OP_CMP_EXT || i_rdata == OP_CMP_IND) begin
               state_d = ST_ARG1;
            end
         end
         ST_OPC2: begin
            addr_d = pc_q;
            state_d = ST_FETCH;
            if (pfx_q == 2'd1 && (i_rdata == OP_CMP_IMM || i_rdata == OP_CMP_DIR ||
                i_rdata == OP_CMP_EXT || i_rdata == OP_CMP_IND)) begin
               state_d = ST_ARG1;
            end else if (pfx_q != 2'd1 && i_rdata == OP_CMP_IND) begin
               state_d = ST_ARG1;
            end
         end
         ST_ARG1: begin
            addr_d = pc_q;
            case (mode_q)
               MD_IMM: state_d = ST_ARG2;
               MD_DIR: state_d = ST_OPND_HI;
               MD_EXT: state_d = ST_ARG2;
               default: state_d = ST_IDLE_IDX;
            endcase
         end
         ST_ARG2: begin
            addr_d = pc_q;
            state_d = (mode_q == MD_IMM) ? ST_IDLE_END : ST_OPND_HI;
         end
         ST_IDLE_IDX: begin
            state_d = ST_OPND_HI;
         end
         ST_OPND_HI: begin
            addr_d = ea_q;
            state_d = ST_OPND_LO;
         end
         ST_OPND_LO: begin
            addr_d = ea_q + 16'h0001;
            state_d = ST_IDLE_END;
         end
         ST_IDLE_END: begin
            state_d = ST_FETCH;
         end
         ST_DAA_2: begin
            addr_d = pc_q;
            state_d = ST_FETCH;
         end
         default: begin
            state_d = ST_FETCH;
         end
      endcase
   end
   assign o_addr = addr_d;
   assign o_rd_wr = 1'b1;
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         state_q <= ST_FETCH;
      end else if (i_load) begin
         state_q <= ST_FETCH;
      end else begin
         state_q <= state_d;
      end
   end
   // ------------------------------------------------------------
   // Program counter
   // ------------------------------------------------------------
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         pc_q <= REG16_RST;
      end else if (i_load) begin
         pc_q <= i_pc;
      end else if (state_q == ST_FETCH || state_q == ST_OPC2 || state_q == ST_ARG1 ||
                   state_q == ST_ARG2) begin
         pc_q <= pc_q + 16'h0001;
      end
   end
   // ------------------------------------------------------------
   // Opcode decode: mode, selected index, prefix
   // ------------------------------------------------------------
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         mode_q <= MD_IMM;
         use_y_q <= 1'b0;
         idx_y_q <= 1'b0;
         pfx_q <= 2'd0;
      end else if (state_q == ST_FETCH || state_q == ST_OPC2) begin
         if (state_q == ST_FETCH) begin
            use_y_q <= (i_rdata == OP_PFX_Y) || (i_rdata == OP_PFX_1A);
            idx_y_q <= (i_rdata == OP_PFX_Y) || (i_rdata == OP_PFX_CD);
            pfx_q <= (i_rdata == OP_PFX_Y) ? 2'd1 : (i_rdata == OP_PFX_1A) ? 2'd2 : 2'd3;
         end
         case (i_rdata)
            OP_CMP_IMM: mode_q <= MD_IMM;
            OP_CMP_DIR: mode_q <= MD_DIR;
            OP_CMP_EXT: mode_q <= MD_EXT;
            default: mode_q <= MD_IND;
         endcase
      end
   end
   // ------------------------------------------------------------
   // Effective address and operand capture
   // ------------------------------------------------------------
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         arg_q <= REG8_RST;
         ea_q <= REG16_RST;
         opnd_q <= REG16_RST;
      end else begin
         case (state_q)
            ST_ARG1: begin
               arg_q <= i_rdata;
               if (mode_q == MD_IMM) begin
                  opnd_q <= {i_rdata, opnd_q[7:0]};
               end else if (mode_q == MD_DIR) begin
                  ea_q <= {ZERO_PAGE, i_rdata};
               end else if (mode_q == MD_IND) begin
                  ea_q <= (idx_y_q ? iy_q : ix_q) + {8'h00, i_rdata};
               end
            end
            ST_ARG2: begin
               if (mode_q == MD_IMM) begin
                  opnd_q <= {opnd_q[15:8], i_rdata};
               end else begin
                  ea_q <= {arg_q, i_rdata};
               end
            end
            ST_OPND_HI: opnd_q <= {i_rdata, opnd_q[7:0]};
            ST_OPND_LO: opnd_q <= {opnd_q[15:8], i_rdata};
            default: begin
            end
         endcase
      end
   end
   // ------------------------------------------------------------
   // Architectural registers
   // ------------------------------------------------------------
   // Index registers are only loaded from outside; compares never write them.
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         ix_q <= REG16_RST;
         iy_q <= REG16_RST;
      end else if (i_load) begin
         ix_q <= i_first_index_register;
         iy_q <= i_second_index_register;
      end
   end
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         acc_q <= REG8_RST;
      end else if (i_load) begin
         acc_q <= i_primary_accumulator;
      end else if (state_q == ST_DAA_2) begin
         acc_q <= daa_res;
      end
   end
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         flags_q <= FLAGS_RST;
      end else if (i_load) begin
         flags_q <= i_condition_flags;
      end else if (state_q == ST_IDLE_END) begin
         // Upper flag bits untouched
         flags_q[FLG_N] <= cmp_bus.n;
         flags_q[FLG_Z] <= cmp_bus.z;
         flags_q[FLG_V] <= cmp_bus.v;
         flags_q[FLG_C] <= cmp_bus.c;
      end else if (state_q == ST_DAA_2) begin
         // Overflow is undefined here, so it is simply held
         flags_q[FLG_N] <= daa_res[7];
         flags_q[FLG_Z] <= (daa_res == 8'h00);
         flags_q[FLG_C] <= corr_hi;
      end
   end
   // ------------------------------------------------------------
   // Completion and status
   // ------------------------------------------------------------
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         done_q <= 1'b0;
         illegal_q <= 1'b0;
      end else begin
         done_q <= !i_load && (state_q == ST_IDLE_END || state_q == ST_DAA_2);
         illegal_q <= !i_load && (state_q == ST_FETCH || state_q == ST_OPC2) &&
                      (state_d == ST_FETCH);
      end
   end
   assign o_pc = pc_q;
   assign o_first_index_register = ix_q;
   assign o_second_index_register = iy_q;
   assign o_primary_accumulator = acc_q;
   assign o_condition_flags = flags_q;
   assign o_instr_done = done_q;
   assign o_illegal = illegal_q;
endmodule // icd_exec
`default_nettype wire

// file: verification/icd_mem_model.sv
// Memory bus partner for the compare / decimal adjust unit
`timescale 1ns/1ps
`default_nettype none
module icd_mem_model (
   // Clock and bus
   input wire logic i_sys_clk,
   input wire logic [15:0] i_addr,
   output logic [7:0] o_rdata
);
   logic [7:0] mem [0:65535];
   logic [7:0] spin_q = 8'hA5;
   initial begin
      for (int i = 0; i < 65536; i++) begin
         mem[i] = 8'h01;
      end
   end
   // Idle reads see a moving pattern so a stale value is never mistaken for data
   always_ff @(posedge i_sys_clk) begin
      spin_q <= spin_q + 8'h3B;
   end
   assign o_rdata = (i_addr == 16'hFFFF) ? spin_q : mem[i_addr];
   task automatic put(input logic [15:0] a, input logic [7:0] d);
      mem[a] = d;
   endtask
endmodule // icd_mem_model
`default_nettype wire

// file: verification/icd_exec_assertions.sv
// Port checker for the compare / decimal adjust unit
`timescale 1ns/1ps
`default_nettype none
module icd_exec_assertions
   import icd_pkg::*;
(
   // All ports of the execution unit
   input wire logic i_sys_clk, i_rst_b, i_load, o_rd_wr, o_instr_done, o_illegal,
   input wire logic [15:0] o_addr, i_pc, i_first_index_register, i_second_index_register,
   input wire logic [15:0] o_pc, o_first_index_register, o_second_index_register,
   input wire logic [7:0] i_rdata, i_primary_accumulator, i_condition_flags,
   input wire logic [7:0] o_primary_accumulator, o_condition_flags
);
   logic [7:0] acc_q;
   logic [7:0] corr;
   always_ff @(posedge i_sys_clk) begin
      acc_q <= o_primary_accumulator;
   end
   assign corr = o_primary_accumulator - acc_q;
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_b);
   // Only decimal adjust moves the accumulator outside a load
   sequence s_adj;
      $past(i_rst_b) && !$past(i_load) && o_primary_accumulator != acc_q;
   endsequence
   sequence s_load;
      i_load ##1 !i_load;
   endsequence
   read_only_a: assert property (o_rd_wr == 1'b1)
      else $error("write cycle seen");
   index_hold_a: assert property ($past(i_rst_b) && !$past(i_load) |->
      $stable(o_first_index_register) && $stable(o_second_index_register)) else $error("index moved");
   flags_keep_a: assert property ($past(i_rst_b) && !$past(i_load) |->
      $stable(o_condition_flags[7:4])) else $error("upper flags moved");
   adj_nz_a: assert property (s_adj |-> o_condition_flags[FLG_N] == o_primary_accumulator[7] &&
      o_condition_flags[FLG_Z] == (o_primary_accumulator == 8'h00)) else $error("adjust N or Z");
   adj_ovf_a: assert property (s_adj |-> $stable(o_condition_flags[FLG_V]))
      else $error("adjust touched V");
   adj_low_a: assert property (s_adj |-> corr[3:0] == 4'h0 || corr[3:0] == 4'h6)
      else $error("bad low correction");
   adj_carry_a: assert property (s_adj |-> (corr[7:4] == 4'h0 || corr[7:4] == 4'h6) &&
      o_condition_flags[FLG_C] == (corr[7:4] == 4'h6)) else $error("bad high correction");
   load_take_a: assert property (s_load |-> o_first_index_register == $past(i_first_index_register) &&
      o_condition_flags == $past(i_condition_flags)) else $error("load lost");
   min_len_a: assert property (s_load |-> ##1 !o_instr_done)
      else $error("done too early");
endmodule // icd_exec_assertions
bind icd_exec icd_exec_assertions i_icd_exec_assertions (.i_sys_clk, .i_rst_b, .i_load, .o_rd_wr, .o_instr_done,
   .o_illegal, .o_addr, .i_pc, .i_first_index_register, .i_second_index_register, .o_pc, .o_first_index_register,
   .o_second_index_register, .i_rdata, .i_primary_accumulator, .i_condition_flags, .o_primary_accumulator,
   .o_condition_flags);
`default_nettype wire

// file: verification/tb_index_compare_decimal_adjust.sv
// Self-checking bench for the compare / decimal adjust unit
`timescale 1ns/1ps
`default_nettype none
module tb_index_compare_decimal_adjust
   import icd_pkg::*;
;
   localparam logic [15:0] PROG = 16'h4000;
   localparam int CYC_X [5] = '{4, 5, 6, 6, 7};
   localparam int CYC_Y [5] = '{5, 6, 7, 7, 7};
   typedef struct {logic adj; logic [15:0] ix, iy, pc; logic [7:0] acc, fl;} icd_note_t;
   icd_note_t notes [$];
   icd_note_t note_now;
   integer seed = 79;
   int mismatches = 0;
   int samples_checked = 0;
   logic i_sys_clk = 1'b0;
   logic i_rst_b = 1'b0;
   logic i_load = 1'b0;
   logic [15:0] i_pc = 16'h0000, i_first_index_register = 16'h0000, i_second_index_register = 16'h0000;
   logic [7:0] i_primary_accumulator = 8'h00, i_condition_flags = 8'h00, i_rdata;
   logic [15:0] o_addr, o_pc, o_first_index_register, o_second_index_register;
   logic [7:0] o_primary_accumulator, o_condition_flags;
   logic o_rd_wr, o_instr_done, o_illegal;
   initial begin
      forever #2 i_sys_clk = ~i_sys_clk;
   end
   icd_exec i_icd_exec (.i_sys_clk, .i_rst_b, .o_addr, .o_rd_wr, .i_rdata, .i_load, .i_pc, .i_first_index_register,
      .i_second_index_register, .i_primary_accumulator, .i_condition_flags, .o_pc, .o_first_index_register,
      .o_second_index_register, .o_primary_accumulator, .o_condition_flags, .o_instr_done, .o_illegal);
   icd_mem_model i_icd_mem_model (.i_sys_clk, .i_addr(o_addr), .o_rdata(i_rdata));
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checked=%0d mismatches=%0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // Loads state, then waits for the completion pulse and counts cycles
   task automatic exec(input icd_note_t n, input logic [7:0] acc, fl, input int ncyc, nidle);
      int k;
      int idle;
      notes.push_back(n);
      @(posedge i_sys_clk);
      i_load <= 1'b1;
      i_pc <= PROG;
      i_first_index_register <= n.ix;
      i_second_index_register <= n.iy;
      i_primary_accumulator <= acc;
      i_condition_flags <= fl;
      @(posedge i_sys_clk);
      i_load <= 1'b0;
      k = 0;
      idle = 0;
      do begin
         @(negedge i_sys_clk);
         k++;
         if (o_addr === IDLE_ADDR) idle++;
      end while (o_instr_done !== 1'b1 && k < 40);
      check(16'(k - 1), 16'(ncyc));
      check(16'(idle), 16'(nidle));
   endtask
   task automatic run_cmp(input logic y, input int md, input int it);
      logic [15:0] base, cv, m, ea, d;
      logic [7:0] off, fl;
      logic [7:0] pg [$];
      icd_note_t n;
      n.adj = 1'b0;
      n.ix = 16'($random(seed));
      n.iy = 16'($random(seed));
      n.acc = 8'($random(seed));
      fl = 8'($random(seed));
      off = 8'($random(seed));
      base = {2'b10, 14'($random(seed))};
      if (md == 3) n.ix = base;
      if (md == 4) n.iy = base;
      cv = y ? n.iy : n.ix;
      m = it == 0 ? cv : it == 1 ? cv ^ 16'h8000 : 16'($random(seed));
      if (y) pg.push_back(md == 3 ? OP_PFX_1A : OP_PFX_Y);
      if (!y && md == 4) pg.push_back(OP_PFX_CD);
      pg.push_back(md == 0 ? OP_CMP_IMM : md == 1 ? OP_CMP_DIR : md == 2 ? OP_CMP_EXT : OP_CMP_IND);
      if (md == 2) pg.push_back(8'hC1);
      pg.push_back(md == 0 ? m[15:8] : off);
      if (md == 0) pg.push_back(m[7:0]);
      ea = md == 1 ? {8'h00, off} : md == 2 ? {8'hC1, off} : base + {8'h00, off};
      i_icd_mem_model.put(ea, m[15:8]);
      i_icd_mem_model.put(ea + 16'h0001, m[7:0]);
      foreach (pg[i]) i_icd_mem_model.put(PROG + 16'(i), pg[i]);
      i_icd_mem_model.put(PROG + 16'(pg.size()), 8'h01);
      d = cv - m;
      n.fl = fl;
      n.fl[FLG_N] = d[15];
      n.fl[FLG_Z] = d == 16'h0000;
      n.fl[FLG_V] = (cv[15] & ~m[15] & ~d[15]) | (~cv[15] & m[15] & d[15]);
      n.fl[FLG_C] = (~cv[15] & m[15]) | (m[15] & d[15]) | (d[15] & ~cv[15]);
      n.pc = PROG + 16'(pg.size());
      exec(n, n.acc, fl, y ? CYC_Y[md] : CYC_X[md], md > 2 ? 2 : 1);
   endtask
   // Accumulator and flags as a BCD add would leave them
   task automatic run_daa(input logic [7:0] a, b, input logic cin);
      logic [8:0] bin;
      int s;
      logic [7:0] fl;
      icd_note_t n;
      bin = {1'b0, a} + {1'b0, b} + 9'(cin);
      s = a[7:4] * 10 + a[3:0] + b[7:4] * 10 + b[3:0] + cin;
      fl = 8'($random(seed));
      fl[FLG_C] = bin[8];
      fl[FLG_H] = ({1'b0, a[3:0]} + {1'b0, b[3:0]} + 5'(cin)) > 5'h0F;
      n.adj = 1'b1;
      n.ix = 16'($random(seed));
      n.iy = 16'($random(seed));
      n.acc = {4'((s / 10) % 10), 4'(s % 10)};
      n.fl = fl;
      n.fl[FLG_C] = s > 99;
      n.fl[FLG_N] = n.acc[7];
      n.fl[FLG_Z] = n.acc == 8'h00;
      n.pc = PROG + 16'h0001;
      i_icd_mem_model.put(PROG, OP_DEC_ADJ);
      i_icd_mem_model.put(PROG + 16'h0001, 8'h01);
      exec(n, bin[7:0], fl, 2, 0);
   endtask
   function automatic logic [7:0] rnd_bcd();
      return {4'({$random(seed)} % 10), 4'({$random(seed)} % 10)};
   endfunction
   always @(negedge i_sys_clk) begin
      if (i_rst_b && o_instr_done === 1'b1) begin
         note_now = notes.pop_front();
         check(16'(o_condition_flags), 16'(note_now.fl));
         check(16'(o_primary_accumulator), 16'(note_now.acc));
         check(o_first_index_register, note_now.ix);
         check(o_second_index_register, note_now.iy);
         check(o_pc, note_now.pc);
      end
   end
   initial begin
      #80000;
      mismatches++;
      print_verdict();
   end
   initial begin
      repeat (3) @(posedge i_sys_clk);
      i_rst_b <= 1'b1;
      // Memory holds only undecoded bytes here, so the first fetch must be flagged illegal
      repeat (2) @(negedge i_sys_clk);
      check(16'(o_illegal), 16'h0001);
      for (int y = 0; y < 2; y++)
         for (int md = 0; md < 5; md++)
            for (int it = 0; it < 3; it++)
               run_cmp(y[0], md, it);
      // Only sums of valid BCD operands are offered to decimal adjust
      run_daa(8'h99, 8'h22, 1'b0);
      run_daa(8'h99, 8'h99, 1'b1);
      run_daa(8'h00, 8'h00, 1'b0);
      repeat (40) run_daa(rnd_bcd(), rnd_bcd(), 1'($random(seed)));
      print_verdict();
   end
endmodule // tb_index_compare_decimal_adjust
`default_nettype wire
